//--- pls_led_rmii.v
// Functional notes
// - Speed strap level latched into control bit 13 during power-up or reset; here it is loaded on the third clk edge after reset release.
// - LED function chosen by two-bit mode field, bits 15:14 of register 1Eh.
// - Mode 00: pin high at 10 Mbps, low at 100 Mbps.
// - Mode 01: pin high without activity, toggles while active.
// - Strap pin is input with pull only in reset, output otherwise; here it stays input until the third clk edge after release.
// - Receive: two data bits per reference clock while carrier/valid is set.
// - Transmit: two data bits accepted per reference clock while enable set.
//
// Speed/activity LED pin with speed strap, and RMII dibit paths.
// Assumes ref_clk is slower than clk/4 and pins are asynchronous to clk.
`timescale 1ns/10ps
`include "pls_map.vh"
module pls_led_rmii #(
   parameter BLINK_CYC = `PLS_BLINK_CYC,
   parameter DEPTH = `PLS_FIFO_DEPTH
) (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Mode register field and link status
   input wire [15:0] led_cfg_reg,
   input wire link_is_100,
   // Strap result
   output wire ctrl_speed_sel,
   // Speed/activity LED pin
   input wire speed_activity_led_pin_i,
   output wire speed_activity_led_pin_o,
   output wire speed_activity_led_pin_oe,
   // RMII pins
   input wire ref_clk,
   output reg [1:0] rxd,
   output reg crs_dv,
   input wire [1:0] txd,
   input wire tx_en,
   // Receive dibits from the line side
   input wire rx_valid,
   output wire rx_ready,
   input wire [1:0] rx_data,
   // Transmit dibits to the line side
   output wire tx_valid,
   input wire tx_ready,
   output wire [1:0] tx_data
);
   localparam [3:0] ST_FIRST = 4'h1;
   localparam [3:0] ST_SECOND = 4'h2;
   localparam [3:0] ST_LATCH = 4'h4;
   localparam [3:0] ST_DRIVE = 4'h8;
   reg [3:0] strap_st_q;
   reg [3:0] strap_st_d;
   reg strap_done_q;
   reg speed_sel_q;
   reg led_s1_q;
   reg led_s2_q;
   reg [2:0] ref_s_q;
   reg [1:0] txd_s1_q;
   reg [1:0] txd_s2_q;
   reg [1:0] txd_s3_q;
   reg ten_s1_q;
   reg ten_s2_q;
   reg ten_s3_q;
   reg [31:0] blink_q;
   reg [12:0] act_q;
   reg blink_lvl_q;
   reg led_o_q;
   reg led_d;
   wire ref_rise;
   wire blink_tick;
   wire [1:0] led_mode;
   wire active;
   wire rxf_valid;
   wire [1:0] rxf_data;
   wire txf_in_ready;
   assign ref_rise = ref_s_q[1] & ~ref_s_q[2];
   assign led_mode = led_cfg_reg[`PLS_LED_MODE_HI:`PLS_LED_MODE_LO];
   assign ctrl_speed_sel = speed_sel_q;
   assign active = (act_q != 13'h0000);
   assign blink_tick = active && (blink_q >= BLINK_CYC - 1);
   // Pull resistor is outside; pin floats as input until strap caught
   assign speed_activity_led_pin_oe = strap_done_q;
   assign speed_activity_led_pin_o = led_o_q;
   // Strap pin passes two flops before the catch state reads it
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         led_s1_q <= 1'b0;
         led_s2_q <= 1'b0;
      end else begin
         led_s1_q <= speed_activity_led_pin_i;
         led_s2_q <= led_s1_q;
      end
   end
   // Strap caught on the third edge after release, whatever its level
   always @* begin
      strap_st_d = strap_st_q;
      case (strap_st_q)
         ST_FIRST: strap_st_d = ST_SECOND;
         ST_SECOND: strap_st_d = ST_LATCH;
         ST_LATCH: strap_st_d = ST_DRIVE;
         ST_DRIVE: strap_st_d = ST_DRIVE;
         default: strap_st_d = ST_FIRST;
      endcase
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_st_q <= ST_FIRST;
         strap_done_q <= 1'b0;
         speed_sel_q <= 1'b0;
      end else begin
         strap_st_q <= strap_st_d;
         if (strap_st_q == ST_LATCH) begin
            speed_sel_q <= led_s2_q;
            strap_done_q <= 1'b1;
         end
      end
   end
   // Activity stretch keeps active for 4096 cycles after crs_dv or tx_en, far shorter than one default blink phase
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         act_q <= 13'h0000;
      end else if (crs_dv | ten_s2_q) begin
         act_q <= `PLS_ACT_HOLD_CYC;
      end else if (active) begin
         act_q <= act_q - 13'h0001;
      end
   end
   // Blink divider gives a one-cycle tick; restarts idle so the first phase is full
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         blink_q <= 32'h00000000;
      end else if (!active || blink_tick) begin
         blink_q <= 32'h00000000;
      end else begin
         blink_q <= blink_q + 32'h00000001;
      end
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         blink_lvl_q <= 1'b1;
      end else if (!active) begin
         blink_lvl_q <= 1'b1;
      end else if (blink_tick) begin
         blink_lvl_q <= ~blink_lvl_q;
      end
   end
   always @* begin
      case (led_mode)
         `PLS_LED_MODE_SPEED: led_d = ~link_is_100;
         `PLS_LED_MODE_ACT: led_d = active ? blink_lvl_q : 1'b1;
         default: led_d = 1'b1;
      endcase
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         led_o_q <= 1'b1;
      end else begin
         led_o_q <= led_d;
      end
   end
   // Reference clock sampled as data; its rise is found behind two flops
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_s_q <= 3'h0;
      end else begin
         ref_s_q <= {ref_s_q[1:0], ref_clk};
      end
   end
   // Third stage keeps the dibit that stood before the rise; the MAC moves it just after
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txd_s1_q <= 2'h0;
         txd_s2_q <= 2'h0;
         txd_s3_q <= 2'h0;
      end else begin
         txd_s1_q <= txd;
         txd_s2_q <= txd_s1_q;
         txd_s3_q <= txd_s2_q;
      end
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ten_s1_q <= 1'b0;
         ten_s2_q <= 1'b0;
         ten_s3_q <= 1'b0;
      end else begin
         ten_s1_q <= tx_en;
         ten_s2_q <= ten_s1_q;
         ten_s3_q <= ten_s2_q;
      end
   end
   // Receive: one dibit per ref_clk period while crs_dv high
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxd <= 2'h0;
         crs_dv <= 1'b0;
      end else if (ref_rise) begin
         crs_dv <= rxf_valid;
         rxd <= rxf_valid ? rxf_data : 2'h0;
      end
   end
   pls_fifo #(.WIDTH(`PLS_DIBIT_W), .DEPTH(DEPTH), .AW(5)) u_rx_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_data),
      .out_valid(rxf_valid),
      .out_ready(ref_rise),
      .out_data(rxf_data)
   );
   // Transmit: accept a dibit on each ref_clk rise while tx_en; overflow drops
   pls_fifo #(.WIDTH(`PLS_DIBIT_W), .DEPTH(DEPTH), .AW(5)) u_tx_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(ref_rise & ten_s3_q),
      .in_ready(txf_in_ready),
      .in_data(txd_s3_q),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );
endmodule

//--- pls_map.vh
// Constants for the speed/activity LED strap and RMII data block.
// Included by the LED and RMII design file; definitions only.
`ifndef PLS_MAP_VH
`define PLS_MAP_VH
`define PLS_LED_MODE_SPEED 2'h0
`define PLS_LED_MODE_ACT 2'h1
`define PLS_CTRL_SPEED_BIT 13
`define PLS_LED_MODE_HI 15
`define PLS_LED_MODE_LO 14
`define PLS_CLK_MHZ 125
`define PLS_BLINK_MS 50
`define PLS_BLINK_CYC (`PLS_BLINK_MS * 1000 * `PLS_CLK_MHZ)
`define PLS_ACT_HOLD_CYC 13'h1000
`define PLS_FIFO_DEPTH 32
`define PLS_DIBIT_W 2
`endif

//--- pls_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock domain and active-low asynchronous reset.
`timescale 1ns/10ps
module pls_fifo #(
   parameter WIDTH = 2,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock and reset
   input wire clk,
   input wire arst_n,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

//--- pls_led_rmii_properties.sv
// Checker for the LED strap pin and RMII outputs
// Bound to pls_led_rmii, sees its ports only
`timescale 1ns/10ps
module pls_props(
   input wire clk, input wire arst_n, input wire [15:0] led_cfg_reg, input wire link_is_100,
   input wire ctrl_speed_sel, input wire speed_activity_led_pin_i,
   input wire speed_activity_led_pin_o, input wire speed_activity_led_pin_oe,
   input wire [1:0] rxd, input wire crs_dv, input wire tx_valid, input wire tx_ready,
   input wire [1:0] tx_data
);
   wire [1:0] m = led_cfg_reg[15:14];
   wire o = speed_activity_led_pin_o;
   wire oe = speed_activity_led_pin_oe;
   wire si = speed_activity_led_pin_i;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   AST_STRAP: assert property ($rose(oe) |-> ctrl_speed_sel == $past(si, 3))
      else $error("strap");
   AST_KEEP: assert property (oe |=> oe && $stable(ctrl_speed_sel)) else $error("keep");
   AST_SPEED: assert property (oe && m == 2'h0 |=> o == !$past(link_is_100))
      else $error("speed");
   AST_RSVD: assert property (oe && m[1] |=> o) else $error("rsvd");
   AST_BLINK: assert property (m == 2'h1 && $past(m) == 2'h1 && $changed(o) |=> $stable(o)[*2])
      else $error("blink");
   AST_RX_IDLE: assert property (!crs_dv |-> rxd == 2'h0) else $error("rx idle");
   AST_RX_HOLD: assert property ($changed({crs_dv, rxd}) |=> $stable({crs_dv, rxd})[*8])
      else $error("rx hold");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx hold");
   cover property (m == 2'h1 && $changed(o));
   cover property ($rose(crs_dv));
   cover property (tx_valid && tx_ready);
endmodule
bind pls_led_rmii pls_props u_props(.*);

//--- pls_mac.sv
// MAC transmit side on RMII
// Changes its pins just after ref_clk rises
`timescale 1ns/10ps
module pls_mac(
   input wire ref_clk,
   output reg [1:0] txd = 2'h0,
   output reg tx_en = 1'h0
);
   // Idle txd is inverted so a stale dibit cannot pass as data
   task send(input [1:0] d, input e);
      @(posedge ref_clk);
      #1 tx_en = e;
      txd = e ? d : ~txd;
   endtask
endmodule

//--- testbench.sv
// Bench for pls_led_rmii with a MAC model
// Expected dibits are queued and compared as they appear
`timescale 1ns/10ps
module testbench;
   reg clk = 0, arst_n = 0, ref_clk = 0, link_is_100 = 0, strap = 1, rx_valid = 0, tx_ready = 0, b;
   reg [15:0] led_cfg_reg = 16'h0;
   reg [1:0] rx_data = 2'h0;
   reg [31:0] rnd = 32'h5C;
   wire ctrl_speed_sel, speed_activity_led_pin_o, speed_activity_led_pin_oe;
   wire crs_dv, rx_ready, tx_valid, tx_en;
   wire [1:0] rxd, txd, tx_data;
   wire speed_activity_led_pin_i = speed_activity_led_pin_oe ? speed_activity_led_pin_o : strap;
   logic [1:0] rxq[$], txq[$];
   int error_cnt = 0, samples_checked = 0, cyc = 0, i, a;
   pls_led_rmii #(.BLINK_CYC(8)) dut(.*);
   pls_mac mac(.*);
   initial forever #4 clk = ~clk;
   // Reference clock runs free, phase unrelated to clk
   initial #37 forever #80 ref_clk = ~ref_clk;
   function [31:0] xs(input [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction
   task chk(input string n, input [7:0] e, input [7:0] s);
      samples_checked++;
      if (e !== s) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, e, s);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task rst(input s);
      #1 arst_n = 0;
      strap = s;
      repeat (3) @(posedge clk);
      chk("oe", 0, speed_activity_led_pin_oe);
      #1 arst_n = 1;
      repeat (4) @(posedge clk);
      #1 chk("strap", s, ctrl_speed_sel);
      chk("oe", 1, speed_activity_led_pin_oe);
   endtask
   always @(posedge ref_clk) if (crs_dv === 1) chk("rxd", rxq.pop_front(), rxd);
   always @(posedge clk) begin
      #1 rnd = xs(rnd);
      tx_ready = rnd[9];
   end
   always @(negedge clk)
      if (tx_valid === 1 && tx_ready === 1) chk("tx", txq.pop_front(), tx_data);
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         tally_and_finish;
      end
   end
   initial begin
      rst(1);
      for (i = 0; i < 8; i++) begin
         led_cfg_reg[15:14] = i[2:1];
         link_is_100 = i[0];
         repeat (3) @(posedge clk);
         #1 chk("led", i[2:1] != 0 || !i[0], speed_activity_led_pin_o);
      end
      led_cfg_reg = 16'h4000;
      rx_valid = 1;
      fork
         begin
            repeat (40) begin
               @(negedge clk) a = rx_ready;
               @(posedge clk);
               if (a) rxq.push_back(rx_data);
               #1 if (a) rx_data = rnd[1:0];
            end
            rx_valid = 0;
         end
         begin
            repeat (16) begin
               txq.push_back(rnd[3:2]);
               mac.send(rnd[3:2], 1);
            end
            mac.send(2'h0, 0);
         end
         begin
            repeat (100) @(posedge clk);
            #1 b = speed_activity_led_pin_o;
            repeat (8) @(posedge clk);
            #1 chk("blink", !b, speed_activity_led_pin_o);
         end
      join
      for (i = 0; i < 3000 && rxq.size() + txq.size() > 0; i++) @(posedge clk);
      chk("left", 0, rxq.size() + txq.size());
      rst(0);
      tally_and_finish;
   end
endmodule
